// [bench/ppgtc_trig_src.sv]
`timescale 1ns/100ps
module ppgtc_trig_src (
  input  wire logic clk,
  input  wire logic want,
  input  wire logic slow,
  output logic      pin
);
  logic d1_reg;
  logic d2_reg;
  always_ff @(posedge clk) begin
    d1_reg <= want;
    d2_reg <= d1_reg;
  end
  // A slow source lags by two clocks, as a driver behind a filter would.
  assign pin = slow ? d2_reg : want;
endmodule : ppgtc_trig_src

// [bench/tb.sv]
`timescale 1ns/100ps
module tb;
  import ppgtc_pkg::*;
  typedef struct {
    int               at;
    int               code;
    logic [CNT_W-1:0] exp;
  } ppgtc_note_s;
  logic             ref_clk = 1'h0;
  logic             rstn = 1'h0;
  logic             want = 1'h0;
  logic             slow = 1'h0;
  logic             run_bit = 1'h0;
  logic             run_wr = 1'h0;
  logic             pol = 1'h1;
  logic             acc = 1'h0;
  logic [1:0]       oe = 2'h3;
  logic             rd_oth = 1'h0;
  logic             rd_bh = 1'h0;
  logic             in1 = 1'h0;
  logic             in2 = 1'h0;
  logic [1:0]       src = 2'h0;
  logic [1:0]       stop_mode = 2'h0;
  logic [CNT_W-1:0] per = 10'h010;
  logic             pin, o1, o2, busy, evt;
  logic [CNT_W-1:0] cap_a, cap_b, cnt;
  logic [31:0]      seed = 32'h11bae7ba;
  int               cyc = 0;
  int               bad_count = 0;
  int               checks = 0;
  ppgtc_note_s      q[$];
  string            nm[5] = '{"busy", "start_event", "outputs", "count", "capture_span"};

  ppgtc_trig_src ppgtc_trig_src_inst (.clk(ref_clk), .want(want), .slow(slow), .pin(pin));
  ppgtc_ctrl #(.W(CNT_W)) ppgtc_ctrl_inst (
    .REF_CLK(ref_clk), .RSTN(rstn), .TRIGGER_PIN(pin), .COUNT_START_SOURCE(src),
    .RUN_BIT(run_bit), .RUN_WRITE_ONE(run_wr), .STOP_MODE(stop_mode), .TRIGGER_POLARITY(pol),
    .TRIGGER_ACCEPT_MODE(acc), .PULSE_OUTPUT_ENABLE(oe), .FIRST_OUTPUT_INITIAL_LEVEL(in1),
    .SECOND_OUTPUT_INITIAL_LEVEL(in2), .PERIOD(per), .DEAD_TIME(10'h002),
    .PULSE_WIDTH(10'h005), .READ_CAPTURE_OTHER(rd_oth), .READ_FALLING_CAPTURE_HIGH(rd_bh),
    .FIRST_PULSE_OUTPUT(o1), .SECOND_PULSE_OUTPUT(o2), .COUNTER_BUSY_FLAG(busy),
    .TRIGGER_START_EVENT(evt), .RISING_CAPTURE_REG(cap_a), .FALLING_CAPTURE_REG(cap_b),
    .COUNT_VALUE(cnt));

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic note(input int dt, input int code, input logic [CNT_W-1:0] v);
    q.push_back('{cyc + dt, code, v});
  endtask : note

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic arm();
    run_bit = 1'h1;
    run_wr = 1'h1;
    step(1);
    run_wr = 1'h0;
  endtask : arm

  task automatic pulse_rd(input logic lock);
    rd_oth = lock;
    rd_bh = ~lock;
    step(1);
    rd_oth = 1'h0;
    rd_bh = 1'h0;
  endtask : pulse_rd

  task automatic close_out();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  // Control settings change only once the counter has stopped.
  task automatic wait_idle();
    int i;
    for (i = 0; i < 200 && busy !== 1'h0; i++) step(1);
    if (i == 200) begin
      $display("ERROR busy expected 0 seen 1");
      bad_count++;
      close_out();
    end
  endtask : wait_idle

  // Both edges land in one period, so their span cancels the input latency.
  task automatic edges(input int len);
    int i;
    for (i = 0; i < 4000 && cnt !== 10'h001; i++) step(1);
    if (i == 4000) begin
      bad_count++;
      close_out();
    end
    want = 1'h1;
    step(len);
    want = 1'h0;
    step(2 * int'(per));
  endtask : edges

  always @(negedge ref_clk) begin
    logic [CNT_W-1:0] got;
    for (int i = 0; i < q.size(); i++) begin
      if (q[i].at == cyc) begin
        case (q[i].code)
          0: got = CNT_W'(busy);
          1: got = CNT_W'(evt);
          2: got = CNT_W'({o2, o1});
          3: got = cnt;
          default: got = cap_b - cap_a;
        endcase
        checks++;
        if (got !== q[i].exp) begin
          bad_count++;
          $display("ERROR %s expected %h seen %h", nm[q[i].code], q[i].exp, got);
        end
        q.delete(i);
        i--;
      end
    end
  end

  initial begin
    logic [31:0] r;
    int          len;
    r = xs();
    in1 = r[0];
    in2 = r[1];
    per = 10'h010 + CNT_W'(r[7:4]);
    len = 2 + int'(r[9:8]);
    repeat (20) @(posedge ref_clk);
    #1;
    rstn = 1'h1;
    step(1);
    src = SRC_TRIGGER;
    for (int p = 1; p >= 0; p--) begin
      pol = p[0];
      // The second pass gates on outputs, but the disabled second output is active at the stop.
      acc = ~p[0];
      oe = p[0] ? 2'h3 : 2'h1;
      want = ~pol;
      step(4);
      want = pol;
      note(3, 1, '0);
      note(4, 0, '0);
      step(6);
      want = ~pol;
      step(4);
      note(2, 0, '0);
      arm();
      step(4);
      want = pol;
      note(3, 1, 10'h001);
      note(4, 0, 10'h001);
      step(8);
      want = ~pol;
      note(5, 0, '0);
      note(5, 2, CNT_W'({in2, in1}));
      step(6);
      run_bit = 1'h0;
      step(2);
    end
    wait_idle();
    src = SRC_CMD_CAPTURE;
    want = 1'h0;
    // Hold mode runs first so that the second start shows the restart levels.
    for (int m = 1; m >= 0; m--) begin
      wait_idle();
      stop_mode = m[1:0];
      note(1, 0, 10'h001);
      note(1, 2, CNT_W'({in2, in1}));
      note(3, 3, 10'h002);
      arm();
      note(3 * int'(per), 0, 10'h001);
      step(3 * int'(per) + 2);
      run_bit = 1'h0;
      note(2, 0, '0);
      if (m == 0) note(2, 2, CNT_W'({in2, in1}));
      step(4);
    end
    wait_idle();
    stop_mode = STOP_PERIOD;
    note(1, 0, 10'h001);
    note(int'(per), 0, 10'h001);
    note(int'(per) + 3, 0, '0);
    arm();
    step(int'(per) + 8);
    wait_idle();
    stop_mode = STOP_INIT;
    slow = 1'h1;
    arm();
    pulse_rd(1'h0);
    edges(len);
    note(1, 4, CNT_W'(len));
    pulse_rd(1'h1);
    edges(len + 3);
    note(1, 4, CNT_W'(len));
    pulse_rd(1'h0);
    step(2 * int'(per));
    note(1, 4, CNT_W'(len + 3));
    step(3);
    close_out();
  end

  initial begin
    for (int i = 0; i < 60000; i++) @(posedge ref_clk);
    $display("ERROR watchdog expected done seen hang");
    bad_count++;
    close_out();
  end
endmodule : tb

// [pkg/ppgtc_pkg.sv]
package ppgtc_pkg;

  localparam int CNT_W = 10;

  // Count start source encodings.
  localparam logic [1:0] SRC_CMD_CAPTURE = 2'h0;
  localparam logic [1:0] SRC_CMD_TRIGGER = 2'h1;
  localparam logic [1:0] SRC_TRIGGER     = 2'h2;

  // Stop mode encodings.
  localparam logic [1:0] STOP_INIT     = 2'h0;
  localparam logic [1:0] STOP_HOLD     = 2'h1;
  localparam logic [1:0] STOP_PERIOD   = 2'h2;

  localparam logic [CNT_W-1:0] CNT_RESET = 10'h000;

  typedef enum logic [1:0] {
    PPGTC_IDLE = 2'b00,
    PPGTC_RUN  = 2'b01,
    PPGTC_WAIT = 2'b11
  } ppgtc_state_e;

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       trig_prev;
    logic       run_prev;
    logic [1:0] stop_mode_prev;
    ppgtc_state_e st;
    logic [CNT_W-1:0] cnt;
    logic       out1;
    logic       out2;
    logic       oneshot_done;
    logic       pend_stop;
    logic       lock;
    logic [CNT_W-1:0] buf_a;
    logic [CNT_W-1:0] buf_b;
    logic [CNT_W-1:0] cap_a;
    logic [CNT_W-1:0] cap_b;
    logic       start_evt;
  } ppgtc_state_s;

endpackage : ppgtc_pkg

// [rtl/ppgtc_ctrl.sv]
`timescale 1ns/100ps
// How it works
// R1 - Trigger-only mode: start on edge, clear at level
// R2 - Trigger-only mode: run bit only arms
// R3 - Capture mode: rising to A, falling to B
// R4 - Buffered capture moves at period end, last wins
// R5 - Capture reads lock; B high read unlocks
// R6 - Software dummy-reads captures in first period
// R7 - Captures only while running, none after one-time stop
// R8 - Polarity selects start edge and stop level
// R9 - One-time stopped: stop triggers only, no starts (trigger-only source still starts on an edge)
// R10 - Run bit zero ignores all triggers
// R11 - Accept-always: triggers act and deactivate outputs
// R12 - Accept-when-inactive: stop deferred until outputs inactive
// R13 - Disabled outputs never block trigger acceptance
// R14 - Stop mode 00: immediate stop, outputs initialised
// R15 - Stop mode 01: immediate stop, outputs held
// R16 - Stop mode 10: stop at period end or trigger
// R17 - Software polls busy before rewriting control
// R18 - One-time mode waits for trigger or run write
// R19 - Run bit stays one after one-time stop
// R20 - Writing stop mode 10 while running restarts
// R21 - Stop modes 00/01 give continuous operation
// R22 - Initial level bit sets output polarity
// R23 - Start event only for trigger-started counts
// R24 - Trigger pin synchronised before all decisions
module ppgtc_ctrl
  import ppgtc_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         REF_CLK,
  input  wire logic         RSTN,
  input  wire logic         TRIGGER_PIN,
  input  wire logic [1:0]   COUNT_START_SOURCE,
  input  wire logic         RUN_BIT,
  input  wire logic         RUN_WRITE_ONE,
  input  wire logic [1:0]   STOP_MODE,
  input  wire logic         TRIGGER_POLARITY,
  input  wire logic         TRIGGER_ACCEPT_MODE,
  input  wire logic [1:0]   PULSE_OUTPUT_ENABLE,
  input  wire logic         FIRST_OUTPUT_INITIAL_LEVEL,
  input  wire logic         SECOND_OUTPUT_INITIAL_LEVEL,
  input  wire logic [W-1:0] PERIOD,
  input  wire logic [W-1:0] DEAD_TIME,
  input  wire logic [W-1:0] PULSE_WIDTH,
  input  wire logic         READ_CAPTURE_OTHER,
  input  wire logic         READ_FALLING_CAPTURE_HIGH,
  output logic              FIRST_PULSE_OUTPUT,
  output logic              SECOND_PULSE_OUTPUT,
  output logic              COUNTER_BUSY_FLAG,
  output logic              TRIGGER_START_EVENT,
  output logic [W-1:0]      RISING_CAPTURE_REG,
  output logic [W-1:0]      FALLING_CAPTURE_REG,
  output logic [W-1:0]      COUNT_VALUE
);

  ppgtc_state_s s_reg;
  ppgtc_state_s s_next;

  logic trig;
  logic rise;
  logic fall;
  logic start_edge;
  logic stop_level;
  logic period_end;
  logic act1;
  logic act2;
  logic outs_inactive;
  logic accept;
  logic capture_mode;
  logic trig_mode;

  // Active phase of the first output within a period, and inactive phase of the second, before initial-level inversion.
  function automatic logic active_at(input logic [W-1:0] c, input logic [W-1:0] dt,
                                     input logic [W-1:0] pw);
    active_at = (c >= dt) && (c < pw);
  endfunction : active_at

  always_comb begin
    trig         = s_reg.sync2; // R24
    rise         = trig & ~s_reg.trig_prev;
    fall         = ~trig & s_reg.trig_prev;
    start_edge   = TRIGGER_POLARITY ? rise : fall; // R8
    stop_level   = TRIGGER_POLARITY ? ~trig : trig; // R8
    period_end   = (s_reg.st == PPGTC_RUN) && (s_reg.cnt == PERIOD - W'(1));
    act1         = active_at(s_reg.cnt, DEAD_TIME, PULSE_WIDTH) && (s_reg.st == PPGTC_RUN);
    act2         = !active_at(s_reg.cnt, W'(0), PULSE_WIDTH + DEAD_TIME)
                   && (s_reg.cnt >= DEAD_TIME) && (s_reg.st == PPGTC_RUN);
    // Outputs whose enable is low never hold off a trigger.
    outs_inactive = !(act1 && PULSE_OUTPUT_ENABLE[0]) && !(act2 && PULSE_OUTPUT_ENABLE[1]); // R13
    accept       = RUN_BIT && (!TRIGGER_ACCEPT_MODE || outs_inactive); // R10 R11 R12
    capture_mode = (COUNT_START_SOURCE == SRC_CMD_CAPTURE);
    trig_mode    = !capture_mode;

    s_next                = s_reg;
    s_next.sync1          = TRIGGER_PIN;
    s_next.sync2          = s_reg.sync1;
    s_next.trig_prev      = trig;
    s_next.run_prev       = RUN_BIT;
    s_next.stop_mode_prev = STOP_MODE;
    s_next.start_evt      = 1'b0;

    // Output levels follow the count, inverted by the initial-level bits.
    s_next.out1 = act1 ^ FIRST_OUTPUT_INITIAL_LEVEL; // R22
    s_next.out2 = act2 ^ SECOND_OUTPUT_INITIAL_LEVEL; // R22

    if (s_reg.st == PPGTC_RUN) begin
      s_next.cnt = period_end ? CNT_RESET : s_reg.cnt + W'(1);
    end

    // Captures go to the buffer; the last edge in a period wins.
    if (capture_mode && RUN_BIT && s_reg.st == PPGTC_RUN) begin // R7
      if (rise) s_next.buf_a = s_reg.cnt; // R3
      if (fall) s_next.buf_b = s_reg.cnt; // R3
    end
    if (period_end && capture_mode && RUN_BIT && !s_reg.lock) begin // R4
      s_next.cap_a = s_next.buf_a;
      s_next.cap_b = s_next.buf_b;
    end
    // The unlock read wins over a lock read in the same cycle.
    if (READ_CAPTURE_OTHER) s_next.lock = 1'b1; // R5
    if (READ_FALLING_CAPTURE_HIGH) s_next.lock = 1'b0; // R5

    if (RUN_WRITE_ONE && !trig_mode) begin
      s_next.st           = PPGTC_RUN;
      s_next.cnt          = CNT_RESET;
      s_next.oneshot_done = 1'b0;
    end else if (RUN_WRITE_ONE && COUNT_START_SOURCE == SRC_CMD_TRIGGER && !stop_level) begin
      s_next.st           = PPGTC_RUN;
      s_next.cnt          = CNT_RESET;
      s_next.oneshot_done = 1'b0;
    end else if (RUN_WRITE_ONE) begin
      s_next.st           = PPGTC_WAIT; // R2
      s_next.oneshot_done = 1'b0;
    end

    if (!RUN_BIT && s_reg.run_prev) begin
      if (STOP_MODE == STOP_PERIOD && s_reg.st == PPGTC_RUN) begin
        s_next.pend_stop = 1'b1; // R16
      end else begin
        s_next.st  = PPGTC_IDLE; // R14 R15
        s_next.cnt = CNT_RESET;
        if (STOP_MODE == STOP_HOLD) begin
          s_next.out1 = s_reg.out1; // R15
          s_next.out2 = s_reg.out2;
        end else begin
          s_next.out1 = FIRST_OUTPUT_INITIAL_LEVEL; // R14
          s_next.out2 = SECOND_OUTPUT_INITIAL_LEVEL;
        end
      end
    end else if (!RUN_BIT && s_reg.st != PPGTC_RUN) begin
      s_next.st = PPGTC_IDLE;
      if (STOP_MODE == STOP_HOLD) begin
        s_next.out1 = s_reg.out1;
        s_next.out2 = s_reg.out2;
      end
    end

    if (RUN_BIT && STOP_MODE == STOP_PERIOD && s_reg.stop_mode_prev != STOP_PERIOD) begin
      s_next.st           = PPGTC_RUN; // R20
      s_next.cnt          = CNT_RESET;
      s_next.oneshot_done = 1'b0;
    end

    if (period_end && (STOP_MODE == STOP_PERIOD || s_reg.pend_stop)) begin // R16 R21
      s_next.st           = trig_mode && RUN_BIT ? PPGTC_WAIT : PPGTC_IDLE; // R18
      s_next.cnt          = CNT_RESET;
      s_next.oneshot_done = 1'b1; // R19
      s_next.pend_stop    = 1'b0;
    end

    if (trig_mode && accept) begin
      if (stop_level && s_reg.st != PPGTC_IDLE) begin // R1 R12
        s_next.st   = PPGTC_WAIT; // R9 R16
        s_next.cnt  = CNT_RESET;
        s_next.out1 = FIRST_OUTPUT_INITIAL_LEVEL; // R11
        s_next.out2 = SECOND_OUTPUT_INITIAL_LEVEL;
        s_next.pend_stop = 1'b0;
      end else if (start_edge && s_reg.st == PPGTC_WAIT
                   && !(STOP_MODE == STOP_PERIOD && s_reg.oneshot_done
                        && COUNT_START_SOURCE != SRC_TRIGGER)) begin // R9
        s_next.st        = PPGTC_RUN; // R1
        s_next.cnt       = CNT_RESET;
        s_next.start_evt = 1'b1; // R23
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign FIRST_PULSE_OUTPUT  = s_reg.out1;
  assign SECOND_PULSE_OUTPUT = s_reg.out2;
  assign COUNTER_BUSY_FLAG   = (s_reg.st == PPGTC_RUN);
  assign TRIGGER_START_EVENT = s_reg.start_evt;
  assign RISING_CAPTURE_REG  = s_reg.cap_a;
  assign FALLING_CAPTURE_REG = s_reg.cap_b;
  assign COUNT_VALUE         = s_reg.cnt;

  chk_idle_ignore: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R10
    !RUN_BIT && !s_reg.run_prev |=> !TRIGGER_START_EVENT)
    else $error("start event while stopped");
  chk_event_busy: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R23
    TRIGGER_START_EVENT |-> COUNTER_BUSY_FLAG && COUNT_VALUE == '0)
    else $error("start event without a fresh count");
  chk_no_capture_event: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R23
    capture_mode && $stable(COUNT_START_SOURCE) |=> !TRIGGER_START_EVENT)
    else $error("start event in capture mode");
  chk_lock_hold: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R5
    s_reg.lock |=> $stable(RISING_CAPTURE_REG))
    else $error("capture changed while locked");
  chk_stop_init: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R14
    !RUN_BIT && s_reg.run_prev && STOP_MODE == STOP_INIT |=>
      !COUNTER_BUSY_FLAG && FIRST_PULSE_OUTPUT == $past(FIRST_OUTPUT_INITIAL_LEVEL))
    else $error("stop mode 00 did not initialise");
  chk_stop_hold: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R15
    !RUN_BIT && s_reg.run_prev && STOP_MODE == STOP_HOLD |=>
      !COUNTER_BUSY_FLAG && $stable(FIRST_PULSE_OUTPUT))
    else $error("stop mode 01 did not hold");
  chk_trig_arm: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R2
    RUN_WRITE_ONE && COUNT_START_SOURCE == SRC_TRIGGER && s_reg.st != PPGTC_RUN |=>
      !COUNTER_BUSY_FLAG)
    else $error("run write started trigger-only mode");
  chk_cmd_start: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R21
    RUN_WRITE_ONE && RUN_BIT && capture_mode |=> COUNTER_BUSY_FLAG ##1 COUNTER_BUSY_FLAG)
    else $error("command start did not run");

  // The second stage only ever copies the first, so no decision sees a metastable value.
  chk_sync_chain: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R24
    s_reg.sync2 == $past(s_reg.sync1))
    else $error("trigger synchroniser broken");
  chk_start_edge: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R1
    TRIGGER_START_EVENT |-> $past(start_edge))
    else $error("start event without a start edge");
  chk_stop_level: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R8
    trig_mode && accept && stop_level && s_reg.st != PPGTC_IDLE |=>
      !COUNTER_BUSY_FLAG && COUNT_VALUE == '0)
    else $error("stop level did not clear the count");
  chk_stop_outputs: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R11
    trig_mode && accept && stop_level && s_reg.st != PPGTC_IDLE |=>
      FIRST_PULSE_OUTPUT == $past(FIRST_OUTPUT_INITIAL_LEVEL)
      && SECOND_PULSE_OUTPUT == $past(SECOND_OUTPUT_INITIAL_LEVEL))
    else $error("stop trigger did not initialise outputs");
  chk_run_low_quiet: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R10
    !RUN_BIT |=> !TRIGGER_START_EVENT)
    else $error("trigger acted while run bit low");
  chk_capture_rise: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R3
    capture_mode && RUN_BIT && s_reg.st == PPGTC_RUN && rise |=>
      s_reg.buf_a == $past(s_reg.cnt))
    else $error("rising edge not captured");
  chk_capture_fall: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R3
    capture_mode && RUN_BIT && s_reg.st == PPGTC_RUN && fall |=>
      s_reg.buf_b == $past(s_reg.cnt))
    else $error("falling edge not captured");
  chk_capture_move: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R4
    period_end && capture_mode && RUN_BIT && !s_reg.lock && !rise |=>
      RISING_CAPTURE_REG == $past(s_reg.buf_a))
    else $error("buffer not moved at period end");
  chk_capture_still: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R4
    !period_end |=> $stable(FALLING_CAPTURE_REG))
    else $error("capture moved inside a period");
  chk_lock_hold_b: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R5
    s_reg.lock |=> $stable(FALLING_CAPTURE_REG))
    else $error("falling capture changed while locked");
  chk_unlock: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R5
    READ_FALLING_CAPTURE_HIGH |=> !s_reg.lock)
    else $error("upper read did not unlock");
  chk_lock_set: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R5
    READ_CAPTURE_OTHER && !READ_FALLING_CAPTURE_HIGH |=> s_reg.lock)
    else $error("capture read did not lock");
  chk_period_wrap: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R21
    period_end && RUN_BIT && capture_mode && STOP_MODE != STOP_PERIOD
      && !s_reg.pend_stop && !RUN_WRITE_ONE |=> COUNTER_BUSY_FLAG && COUNT_VALUE == '0)
    else $error("continuous mode did not wrap");
  chk_oneshot_end: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R16
    period_end && STOP_MODE == STOP_PERIOD |=> !COUNTER_BUSY_FLAG && s_reg.oneshot_done)
    else $error("one-time mode ran past period end");
  chk_oneshot_wait: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R18
    period_end && STOP_MODE == STOP_PERIOD && trig_mode && RUN_BIT |=>
      s_reg.st == PPGTC_WAIT)
    else $error("one-time trigger mode did not rearm");
  // Switching to one-time mode mid-run restarts the period rather than finishing it.
  chk_restart: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R20
    RUN_BIT && STOP_MODE == STOP_PERIOD && s_reg.stop_mode_prev != STOP_PERIOD
      && !period_end && !(trig_mode && accept && stop_level) |=>
      COUNTER_BUSY_FLAG && COUNT_VALUE == '0)
    else $error("one-time select did not restart");
  chk_hold_active: assert property (@(posedge REF_CLK) disable iff (!RSTN) // R12
    trig_mode && RUN_BIT && s_reg.run_prev && TRIGGER_ACCEPT_MODE && !outs_inactive
      && s_reg.st == PPGTC_RUN && !period_end && !RUN_WRITE_ONE |=> COUNTER_BUSY_FLAG)
    else $error("trigger stopped active outputs");

  cov_trig_start: cover property (@(posedge REF_CLK) disable iff (!RSTN) TRIGGER_START_EVENT);
  cov_capture: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    period_end && capture_mode && !s_reg.lock);
  cov_oneshot: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    period_end && STOP_MODE == STOP_PERIOD);
  cov_trig_stop: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    trig_mode && accept && stop_level && s_reg.st == PPGTC_RUN);
  cov_hold_stop: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    !RUN_BIT && s_reg.run_prev && STOP_MODE == STOP_HOLD);

endmodule : ppgtc_ctrl
